// *** pswc_map.vh ***
`ifndef PSWC_MAP_VH
`define PSWC_MAP_VH
// register offsets on the plain register port
`define PSWC_OFF_SA 4'h0
`define PSWC_OFF_RA 4'h1
`define PSWC_OFF_SB 4'h2
`define PSWC_OFF_RB 4'h3
`define PSWC_OFF_CFG 4'h4
`define PSWC_OFF_CTRL 4'h5
`define PSWC_OFF_MTX 4'h6
`define PSWC_OFF_STAT 4'h7
`define PSWC_OFF_CAP 4'h8
`define PSWC_OFF_CNT 4'h9
// configuration fields
`define PSWC_CFG_MODE_LO 0
`define PSWC_CFG_MODE_HI 1
`define PSWC_CFG_POL 2
`define PSWC_CFG_FIFTY 3
`define PSWC_CFG_AUTO 4
`define PSWC_CFG_LOCK 5
`define PSWC_CFG_PLLSEL 6
`define PSWC_CFG_SLAVE 7
// control fields
`define PSWC_CTRL_RUN 0
`define PSWC_CTRL_IN0_EN 1
`define PSWC_CTRL_IN0_FAULT 2
`define PSWC_CTRL_IN1_EN 3
`define PSWC_CTRL_IN1_FAULT 4
`define PSWC_CTRL_DUPC_SEL 5
`define PSWC_CTRL_DUPD_SEL 6
`define PSWC_CTRL_MTX_EN 7
// status fields
`define PSWC_STAT_OVF 0
`define PSWC_STAT_FLT 1
`define PSWC_STAT_CAP 2
`define PSWC_STAT_RUN 3
// running modes
`define PSWC_MODE_ONE 2'h0
`define PSWC_MODE_TWO 2'h1
`define PSWC_MODE_FOUR 2'h2
`define PSWC_MODE_CEN 2'h3
// reset values
`define PSWC_CFG_RST 8'h04
`define PSWC_CTRL_RST 8'h00
`define PSWC_MTX_RST 8'h00
`define PSWC_CMP_RST 12'h000
`define PSWC_RB_RST 16'h0000
// timing counts in counter clocks
`define PSWC_FOUR_DT_EXTRA 12'h002
`endif

// *** pswc_input.v ***
`timescale 1ns/10ps
// one input module per input pin: synchronise, then act as retrigger or fault
module pswc_input (
    input wire clk,
    input wire reset,
    input wire ce,
    input wire pin,
    input wire enable,
    input wire role_fault,
    output reg retrig,
    output reg fault
);
    reg s1_q;
    reg s2_q;
    reg s3_q;

    always @(posedge clk)
    begin
        if (reset)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            retrig <= 1'b0;
            fault <= 1'b0;
        end
        else if (ce)
        begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            retrig <= enable & ~role_fault & s2_q & ~s3_q;
            fault <= enable & role_fault & s2_q;
        end
    end
endmodule // pswc_input

// *** pswc_ctrl.v ***
// Overview of operation
// - up/down counter between register limits per mode
// - half A drives output a, B drives b
// - each input pin has its own input module; both act on both halves
// - variant with two or four outputs
// - outputs c and d copy a or b
// - output matrix sets levels per sub-cycle, four-output variant only
// - polarity select inverts outputs when active low
// - 12-bit set and reset compares per half
// - half-B reset bits 15:12 give fraction
// - counter clocked from io clock or pll
// - chain sync input and output
// - chain halt input and output
// - two inputs, each retrigger or fault
// - retrigger copies counter to capture register
// - one irq: overflow, fault or capture
// - emergency forces hi-z or inactive by fuse
// - new values load together at cycle end
// - auto hold needs half-B reset last; lock holds
// - four ramp: dead set+2, on reset
// - fifty percent reuses half-B values for A
`timescale 1ns/10ps
`include "pswc_map.vh"
module pswc_ctrl #(
    parameter FOUR_OUTPUTS = 1
) (
    input wire CLK,
    input wire RESET,
    input wire CE,
    input wire [3:0] ADDR,
    input wire [15:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [15:0] RDATA,
    input wire PLL_CLK,
    input wire SENSE_INPUT_0,
    input wire CMP_INPUT_1,
    input wire CHAIN_SYNC_IN,
    input wire CHAIN_HALT_IN,
    input wire EMERGENCY_IN,
    input wire FUSE_HIZ,
    output reg WAVE_OUT_A,
    output reg WAVE_OUT_B,
    output reg WAVE_OUT_DUP_C,
    output reg WAVE_OUT_DUP_D,
    output reg WAVE_OUT_OE_N,
    output reg CHAIN_SYNC_OUT,
    output reg CHAIN_HALT_OUT,
    output reg ADC_SYNC_PULSE,
    output reg WAVE_CTRL_IRQ
);
    // shadow registers written by software
    reg [11:0] sa_sh_q;
    reg [11:0] ra_sh_q;
    reg [11:0] sb_sh_q;
    reg [15:0] rb_sh_q;
    reg [7:0] cfg_q;
    reg [7:0] ctrl_q;
    reg [7:0] mtx_sh_q;
    reg rb_last_q;
    // working set, loaded as a whole
    reg [11:0] sa_w_q;
    reg [11:0] ra_w_q;
    reg [11:0] sb_w_q;
    reg [11:0] rb_w_q;
    reg [3:0] frac_w_q;
    reg [1:0] mode_w_q;
    reg [7:0] mtx_w_q;
    reg dupc_w_q;
    reg dupd_w_q;
    // counter state
    reg [11:0] cnt_q;
    reg [1:0] ramp_q;
    reg dir_q;
    reg stretch_q;
    reg ext_q;
    reg [3:0] acc_q;
    reg [11:0] retrigger_capture_value_q;
    reg ovf_q;
    reg flt_q;
    reg cap_q;
    reg pll_d_q;
    reg sync_d_q;

    // pins from outside the clock domain: two flops each
    wire [4:0] raw_in = {PLL_CLK, CHAIN_SYNC_IN, CHAIN_HALT_IN, EMERGENCY_IN, FUSE_HIZ};
    wire [4:0] s_in;
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1)
        begin : g_sync
            reg f1_q;
            reg f2_q;
            always @(posedge CLK)
            begin
                if (RESET)
                begin
                    f1_q <= 1'b0;
                    f2_q <= 1'b0;
                end
                else if (CE)
                begin
                    f1_q <= raw_in[gi];
                    f2_q <= f1_q;
                end
            end
            assign s_in[gi] = f2_q;
        end
    endgenerate
    wire pll_s = s_in[4];
    wire sync_s = s_in[3];
    wire halt_s = s_in[2];
    wire emerg_s = s_in[1];
    wire fuse_hiz_s = s_in[0];

    wire retrig_a;
    wire retrig_b;
    wire fault_a;
    wire fault_b;
    pswc_input u_in_a (
        .clk(CLK),
        .reset(RESET),
        .ce(CE),
        .pin(SENSE_INPUT_0),
        .enable(ctrl_q[`PSWC_CTRL_IN0_EN]),
        .role_fault(ctrl_q[`PSWC_CTRL_IN0_FAULT]),
        .retrig(retrig_a),
        .fault(fault_a)
    );
    pswc_input u_in_b (
        .clk(CLK),
        .reset(RESET),
        .ce(CE),
        .pin(CMP_INPUT_1),
        .enable(ctrl_q[`PSWC_CTRL_IN1_EN]),
        .role_fault(ctrl_q[`PSWC_CTRL_IN1_FAULT]),
        .retrig(retrig_b),
        .fault(fault_b)
    );

    wire slave = cfg_q[`PSWC_CFG_SLAVE];
    wire run_bit = ctrl_q[`PSWC_CTRL_RUN];
    wire run_en = run_bit & ~(slave & halt_s);
    // pll selected: count on each sampled pll rising edge
    wire pll_rise = pll_s & ~pll_d_q;
    wire tick = run_en & (cfg_q[`PSWC_CFG_PLLSEL] ? pll_rise : 1'b1);
    wire sync_rise = sync_s & ~sync_d_q;
    wire retrig = retrig_a | retrig_b;
    wire restart = retrig | (slave & sync_rise);
    wire fault = fault_a | fault_b;

    // fifty percent: half A follows half B
    wire fifty = cfg_q[`PSWC_CFG_FIFTY];
    wire [11:0] sa_e = fifty ? sb_w_q : sa_w_q;
    wire [11:0] ra_e = fifty ? rb_w_q : ra_w_q;

    reg [11:0] tc;
    reg last_ramp;
    reg lvl_a;
    reg lvl_b;
    reg sub_b;
    always @*
    begin
        tc = rb_w_q;
        last_ramp = 1'b1;
        lvl_a = 1'b0;
        lvl_b = 1'b0;
        sub_b = 1'b0;
        case (mode_w_q)
            `PSWC_MODE_FOUR:
            begin
                case (ramp_q)
                    2'h0: tc = sa_e + `PSWC_FOUR_DT_EXTRA - 12'h001;
                    2'h1: tc = (ra_e == 12'h000) ? 12'h000 : ra_e - 12'h001;
                    2'h2: tc = sb_w_q + `PSWC_FOUR_DT_EXTRA - 12'h001;
                    default: tc = (rb_w_q == 12'h000) ? 12'h000 : rb_w_q - 12'h001;
                endcase
                last_ramp = (ramp_q == 2'h3);
                lvl_a = (ramp_q == 2'h1);
                lvl_b = (ramp_q == 2'h3);
                sub_b = ramp_q[1];
            end
            `PSWC_MODE_TWO:
            begin
                tc = ramp_q[0] ? rb_w_q : ra_e;
                last_ramp = ramp_q[0];
                lvl_a = ~ramp_q[0] & (cnt_q > sa_e);
                lvl_b = ramp_q[0] & (cnt_q > sb_w_q);
                sub_b = ramp_q[0];
            end
            `PSWC_MODE_CEN:
            begin
                lvl_a = (cnt_q < sa_e);
                lvl_b = (cnt_q >= sb_w_q);
                sub_b = dir_q;
            end
            default:
            begin
                lvl_a = (cnt_q > sa_e) & (cnt_q <= ra_e);
                lvl_b = (cnt_q > sb_w_q) & (cnt_q <= rb_w_q);
                sub_b = (cnt_q > ra_e);
            end
        endcase
    end

    wire is_cen = (mode_w_q == `PSWC_MODE_CEN);
    wire at_end = is_cen ? (dir_q & (cnt_q == 12'h000)) : (last_ramp & (cnt_q == tc));
    // one extra clock for the stretched cycles of the 16-cycle frame
    wire hold_one = ext_q & ~stretch_q;
    wire cyc_end = tick & at_end & ~hold_one & ~restart;
    wire [4:0] acc_sum = {1'b0, acc_q} + {1'b0, frac_w_q};
    wire upd_ok = cfg_q[`PSWC_CFG_AUTO] ? rb_last_q : ~cfg_q[`PSWC_CFG_LOCK];
    wire load = (~run_bit | cyc_end) & upd_ok;

    wire wr_sa = WR & (ADDR == `PSWC_OFF_SA);
    wire wr_ra = WR & (ADDR == `PSWC_OFF_RA);
    wire wr_sb = WR & (ADDR == `PSWC_OFF_SB);
    wire wr_rb = WR & (ADDR == `PSWC_OFF_RB);
    wire wr_st = WR & (ADDR == `PSWC_OFF_STAT);

    always @(posedge CLK)
    begin
        if (RESET)
        begin
            sa_sh_q <= `PSWC_CMP_RST;
            ra_sh_q <= `PSWC_CMP_RST;
            sb_sh_q <= `PSWC_CMP_RST;
            rb_sh_q <= `PSWC_RB_RST;
            cfg_q <= `PSWC_CFG_RST;
            ctrl_q <= `PSWC_CTRL_RST;
            mtx_sh_q <= `PSWC_MTX_RST;
            rb_last_q <= 1'b0;
            sa_w_q <= `PSWC_CMP_RST;
            ra_w_q <= `PSWC_CMP_RST;
            sb_w_q <= `PSWC_CMP_RST;
            rb_w_q <= `PSWC_CMP_RST;
            frac_w_q <= 4'h0;
            mode_w_q <= `PSWC_MODE_ONE;
            mtx_w_q <= `PSWC_MTX_RST;
            dupc_w_q <= 1'b0;
            dupd_w_q <= 1'b0;
            RDATA <= 16'h0000;
        end
        else if (CE)
        begin
            if (wr_sa)
                sa_sh_q <= WDATA[11:0];
            if (wr_ra)
                ra_sh_q <= WDATA[11:0];
            if (wr_sb)
                sb_sh_q <= WDATA[11:0];
            if (wr_rb)
                rb_sh_q <= WDATA;
            if (WR & (ADDR == `PSWC_OFF_CFG))
                cfg_q <= WDATA[7:0];
            if (WR & (ADDR == `PSWC_OFF_CTRL))
                ctrl_q <= WDATA[7:0];
            if (WR & (ADDR == `PSWC_OFF_MTX))
                mtx_sh_q <= WDATA[7:0];
            // a fresh half-B reset write outranks the clear after a load
            if (wr_rb)
                rb_last_q <= 1'b1;
            else if (wr_sa | wr_ra | wr_sb | load)
                rb_last_q <= 1'b0;
            if (load)
            begin
                sa_w_q <= sa_sh_q;
                ra_w_q <= ra_sh_q;
                sb_w_q <= sb_sh_q;
                rb_w_q <= rb_sh_q[11:0];
                frac_w_q <= rb_sh_q[15:12];
                mode_w_q <= cfg_q[`PSWC_CFG_MODE_HI:`PSWC_CFG_MODE_LO];
                mtx_w_q <= mtx_sh_q;
                dupc_w_q <= ctrl_q[`PSWC_CTRL_DUPC_SEL];
                dupd_w_q <= ctrl_q[`PSWC_CTRL_DUPD_SEL];
            end
            RDATA <= 16'h0000;
            if (RD)
            begin
                case (ADDR)
                    `PSWC_OFF_SA: RDATA <= {4'h0, sa_sh_q};
                    `PSWC_OFF_RA: RDATA <= {4'h0, ra_sh_q};
                    `PSWC_OFF_SB: RDATA <= {4'h0, sb_sh_q};
                    `PSWC_OFF_RB: RDATA <= rb_sh_q;
                    `PSWC_OFF_CFG: RDATA <= {8'h00, cfg_q};
                    `PSWC_OFF_CTRL: RDATA <= {8'h00, ctrl_q};
                    `PSWC_OFF_MTX: RDATA <= {8'h00, mtx_sh_q};
                    `PSWC_OFF_STAT: RDATA <= {12'h000, run_en, cap_q, flt_q, ovf_q};
                    `PSWC_OFF_CAP: RDATA <= {4'h0, retrigger_capture_value_q};
                    `PSWC_OFF_CNT: RDATA <= {4'h0, cnt_q};
                    default: RDATA <= 16'h0000;
                endcase
            end
        end
    end

    // counter and sequence
    always @(posedge CLK)
    begin
        if (RESET)
        begin
            cnt_q <= 12'h000;
            ramp_q <= 2'h0;
            dir_q <= 1'b0;
            stretch_q <= 1'b0;
            ext_q <= 1'b0;
            acc_q <= 4'h0;
            pll_d_q <= 1'b0;
            sync_d_q <= 1'b0;
        end
        else if (CE)
        begin
            pll_d_q <= pll_s;
            sync_d_q <= sync_s;
            if (~run_bit | restart)
            begin
                cnt_q <= 12'h000;
                ramp_q <= 2'h0;
                dir_q <= 1'b0;
                stretch_q <= 1'b0;
            end
            else if (tick)
            begin
                if (at_end & hold_one)
                    stretch_q <= 1'b1;
                else if (at_end)
                begin
                    cnt_q <= 12'h000;
                    ramp_q <= 2'h0;
                    dir_q <= 1'b0;
                    stretch_q <= 1'b0;
                    acc_q <= acc_sum[3:0];
                    ext_q <= acc_sum[4];
                end
                else if (is_cen)
                begin
                    // top value is held two clocks: once rising, once falling
                    if (~dir_q & (cnt_q == tc))
                        dir_q <= 1'b1;
                    else if (dir_q)
                        cnt_q <= cnt_q - 12'h001;
                    else
                        cnt_q <= cnt_q + 12'h001;
                end
                else if (cnt_q == tc)
                begin
                    cnt_q <= 12'h000;
                    ramp_q <= ramp_q + 2'h1;
                end
                else
                    cnt_q <= cnt_q + 12'h001;
            end
        end
    end

    // capture and sticky flags; a set in the clear cycle wins
    wire [2:0] clr = wr_st ? WDATA[2:0] : 3'h0;
    always @(posedge CLK)
    begin
        if (RESET)
        begin
            retrigger_capture_value_q <= 12'h000;
            ovf_q <= 1'b0;
            flt_q <= 1'b0;
            cap_q <= 1'b0;
        end
        else if (CE)
        begin
            if (retrig)
                retrigger_capture_value_q <= cnt_q;
            ovf_q <= cyc_end | (ovf_q & ~clr[`PSWC_STAT_OVF]);
            flt_q <= fault | (flt_q & ~clr[`PSWC_STAT_FLT]);
            cap_q <= retrig | (cap_q & ~clr[`PSWC_STAT_CAP]);
        end
    end

    // output stage
    reg [3:0] vec;
    always @*
    begin
        if (ctrl_q[`PSWC_CTRL_MTX_EN] & (FOUR_OUTPUTS != 0))
            vec = sub_b ? mtx_w_q[7:4] : mtx_w_q[3:0];
        else
            vec = {dupd_w_q ? lvl_b : lvl_a, dupc_w_q ? lvl_b : lvl_a, lvl_b, lvl_a};
        if (FOUR_OUTPUTS == 0)
            vec[3:2] = 2'h0;
        // fault, stop and emergency all park the outputs inactive
        if (fault | ~run_bit | emerg_s)
            vec = 4'h0;
    end
    wire inact = ~cfg_q[`PSWC_CFG_POL];
    wire [3:0] pins = vec ^ {4{inact}};

    always @(posedge CLK)
    begin
        if (RESET)
        begin
            WAVE_OUT_A <= 1'b0;
            WAVE_OUT_B <= 1'b0;
            WAVE_OUT_DUP_C <= 1'b0;
            WAVE_OUT_DUP_D <= 1'b0;
            WAVE_OUT_OE_N <= 1'b0;
            CHAIN_SYNC_OUT <= 1'b0;
            CHAIN_HALT_OUT <= 1'b1;
            ADC_SYNC_PULSE <= 1'b0;
            WAVE_CTRL_IRQ <= 1'b0;
        end
        else if (CE)
        begin
            WAVE_OUT_A <= pins[0];
            WAVE_OUT_B <= pins[1];
            WAVE_OUT_DUP_C <= pins[2];
            WAVE_OUT_DUP_D <= pins[3];
            WAVE_OUT_OE_N <= emerg_s & fuse_hiz_s;
            CHAIN_SYNC_OUT <= cyc_end;
            CHAIN_HALT_OUT <= ~run_en;
            ADC_SYNC_PULSE <= tick & ~dir_q & (cnt_q == ra_e);
            WAVE_CTRL_IRQ <= ovf_q | flt_q | cap_q;
        end
    end
endmodule // pswc_ctrl

// *** pswc_chk.sv ***
`timescale 1ns/10ps
module pswc_chk (
    input wire CLK,
    input wire RESET,
    input wire CE,
    input wire RD,
    input wire [15:0] RDATA,
    input wire EMERGENCY_IN,
    input wire FUSE_HIZ,
    input wire WAVE_OUT_A,
    input wire WAVE_OUT_B,
    input wire WAVE_OUT_DUP_C,
    input wire WAVE_OUT_DUP_D,
    input wire WAVE_OUT_OE_N,
    input wire CHAIN_SYNC_OUT,
    input wire CHAIN_HALT_OUT,
    input wire ADC_SYNC_PULSE,
    input wire WAVE_CTRL_IRQ
);
    default clocking dc @(posedge CLK);
    endclocking
    default disable iff (RESET);
    AST_RST_IDLE: assert property ($fell(RESET) |-> !WAVE_OUT_A && !WAVE_OUT_B
        && !WAVE_OUT_DUP_C && !WAVE_OUT_DUP_D && CHAIN_HALT_OUT && !WAVE_CTRL_IRQ)
        else $error("outputs not idle after reset");
    AST_RD_IDLE: assert property (CE && !RD |=> RDATA == 16'h0000)
        else $error("read data outside read answer");
    AST_SYNC_ONE: assert property (CHAIN_SYNC_OUT |=> !CHAIN_SYNC_OUT)
        else $error("sync output longer than one cycle");
    AST_HALT_QUIET: assert property (CHAIN_HALT_OUT && $past(CHAIN_HALT_OUT)
        |-> !CHAIN_SYNC_OUT && !ADC_SYNC_PULSE)
        else $error("cycle activity while halted");
    AST_IRQ_OVF: assert property (CHAIN_SYNC_OUT |-> ##[0:2] WAVE_CTRL_IRQ)
        else $error("cycle end gave no interrupt");
    AST_ADC_ONE: assert property (ADC_SYNC_PULSE |=> !ADC_SYNC_PULSE)
        else $error("adc sync longer than one cycle");
    AST_EMG_HIZ: assert property ((CE && EMERGENCY_IN && FUSE_HIZ) [*4]
        |=> WAVE_OUT_OE_N)
        else $error("emergency did not release outputs");
    AST_EMG_INACT: assert property ((CE && EMERGENCY_IN && !FUSE_HIZ) [*4]
        |=> !WAVE_OUT_OE_N && WAVE_OUT_A == WAVE_OUT_B && WAVE_OUT_B == WAVE_OUT_DUP_C
        && WAVE_OUT_DUP_C == WAVE_OUT_DUP_D)
        else $error("emergency did not park outputs");
    AST_OE_NORMAL: assert property ((CE && !EMERGENCY_IN) [*4] |=> !WAVE_OUT_OE_N)
        else $error("outputs released without emergency");
endmodule // pswc_chk

bind pswc_ctrl pswc_chk chk (
    .CLK(CLK), .RESET(RESET), .CE(CE), .RD(RD), .RDATA(RDATA),
    .EMERGENCY_IN(EMERGENCY_IN), .FUSE_HIZ(FUSE_HIZ), .WAVE_OUT_A(WAVE_OUT_A),
    .WAVE_OUT_B(WAVE_OUT_B), .WAVE_OUT_DUP_C(WAVE_OUT_DUP_C),
    .WAVE_OUT_DUP_D(WAVE_OUT_DUP_D), .WAVE_OUT_OE_N(WAVE_OUT_OE_N),
    .CHAIN_SYNC_OUT(CHAIN_SYNC_OUT), .CHAIN_HALT_OUT(CHAIN_HALT_OUT),
    .ADC_SYNC_PULSE(ADC_SYNC_PULSE), .WAVE_CTRL_IRQ(WAVE_CTRL_IRQ)
);

// *** pswc_stage.sv ***
`timescale 1ns/10ps
// power stage and sensors: counts gate-high cycles per waveform cycle
module pswc_stage #(
    parameter WIDTH = 4
) (
    input wire clk,
    input wire sync,
    input wire a,
    input wire b,
    input wire c,
    input wire d,
    input wire kick,
    input wire hold,
    output wire sense0,
    output wire sense1,
    output logic [4:0][7:0] seen
);
    logic [4:0][7:0] cnt_q;
    logic [2:0] k_q = 3'h0;
    logic h_q = 1'b0;
    wire [4:0] lvl = {d, c, b, a, 1'b1};
    assign sense0 = (k_q != 3'h0);
    assign sense1 = h_q;
    always @(posedge clk)
    begin
        // window restarts at each sync pulse, so one window is one cycle
        for (int i = 0; i < 5; i++)
            cnt_q[i] <= (sync ? 8'h00 : cnt_q[i]) + {7'h00, lvl[i]};
        if (sync)
            seen <= cnt_q;
        if (kick)
            k_q <= 3'(WIDTH);
        else if (k_q != 3'h0)
            k_q <= k_q - 3'h1;
        h_q <= hold;
    end
endmodule // pswc_stage

// *** power_stage_waveform_controller_test.sv ***
`timescale 1ns/10ps
module power_stage_waveform_controller_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic emg = 1'b0;
    logic fuse = 1'b0;
    logic kick = 1'b0;
    logic hold = 1'b0;
    logic pll = 1'b0;
    logic syn = 1'b0;
    logic halt = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    wire [15:0] rdata;
    wire wa, wb, wc, wd, oen, so, ho, adc, irq, s0, s1;
    wire [4:0][7:0] seen;
    int miscompares = 0;
    int checked = 0;

    pswc_ctrl #(.FOUR_OUTPUTS(1)) dut (
        .CLK(clk), .RESET(rst), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .PLL_CLK(pll), .SENSE_INPUT_0(s0), .CMP_INPUT_1(s1),
        .CHAIN_SYNC_IN(syn), .CHAIN_HALT_IN(halt), .EMERGENCY_IN(emg), .FUSE_HIZ(fuse),
        .WAVE_OUT_A(wa), .WAVE_OUT_B(wb), .WAVE_OUT_DUP_C(wc), .WAVE_OUT_DUP_D(wd),
        .WAVE_OUT_OE_N(oen), .CHAIN_SYNC_OUT(so), .CHAIN_HALT_OUT(ho),
        .ADC_SYNC_PULSE(adc), .WAVE_CTRL_IRQ(irq)
    );
    pswc_stage stage (
        .clk(clk), .sync(so), .a(wa), .b(wb), .c(wc), .d(wd), .kick(kick), .hold(hold),
        .sense0(s0), .sense1(s1), .seen(seen)
    );

    initial
    begin
        forever #20 clk = ~clk;
    end

    // free-running pll pin at half the clock rate
    always @(posedge clk)
        pll <= ~pll;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: saw %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        // idle edge: a following write must not reassign wr in the same step
        @(posedge clk);
    endtask

    task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        chk(rdata, e);
    endtask

    task automatic ticks(input int n);
        repeat (n) @(posedge clk);
    endtask

    // three cycles so a pending load has surely landed
    task automatic wave(input logic [7:0] p, input logic [7:0] a, input logic [7:0] b);
        repeat (3) @(posedge so);
        ticks(2);
        chk(16'(seen[0]), 16'(p));
        chk(16'(seen[1]), 16'(a));
        chk(16'(seen[2]), 16'(b));
    endtask

    task automatic t_reset_vals();
        logic [3:0] a;
        for (int i = 0; i < 11; i++)
        begin
            a = (i == 10) ? 4'hF : 4'(i);
            rd_reg(a, (a == 4'h4) ? 16'h0004 : 16'h0000);
        end
        chk({11'h000, ho, wa, wb, wc, wd}, 16'h0010);
        wr_reg(4'h0, 16'h0ABC);
        wr_reg(4'h3, 16'hF123);
        rd_reg(4'h0, 16'h0ABC);
        rd_reg(4'h3, 16'hF123);
    endtask

    task automatic t_modes();
        logic [7:0] p[4] = '{8'h0A, 8'h10, 8'h18, 8'h14};
        logic [7:0] a[4] = '{8'h03, 8'h03, 8'h05, 8'h04};
        logic [7:0] b[4] = '{8'h05, 8'h05, 8'h09, 8'h0C};
        wr_reg(4'h0, 16'h0002);
        wr_reg(4'h1, 16'h0005);
        wr_reg(4'h2, 16'h0004);
        wr_reg(4'h3, 16'h0009);
        for (int m = 0; m < 4; m++)
        begin
            wr_reg(4'h5, 16'h0000);
            wr_reg(4'h4, 16'h0004 | 16'(m));
            wr_reg(4'h5, 16'h0021);
            wave(p[m], a[m], b[m]);
            chk(16'(seen[3]), 16'(b[m]));
            chk(16'(seen[4]), 16'(a[m]));
        end
        wr_reg(4'h5, 16'h0000);
        wr_reg(4'h4, 16'h000E);
        wr_reg(4'h5, 16'h0001);
        wave(8'h1E, 8'h09, 8'h09);
    endtask

    task automatic t_hold();
        wr_reg(4'h4, 16'h0006);
        wave(8'h18, 8'h05, 8'h09);
        wr_reg(4'h4, 16'h0026);
        wr_reg(4'h3, 16'h0005);
        wave(8'h18, 8'h05, 8'h09);
        wr_reg(4'h4, 16'h0006);
        wave(8'h14, 8'h05, 8'h05);
        wr_reg(4'h4, 16'h0016);
        wr_reg(4'h0, 16'h0007);
        wave(8'h14, 8'h05, 8'h05);
        wr_reg(4'h3, 16'h0009);
        wave(8'h1D, 8'h05, 8'h09);
    endtask

    task automatic t_frac_pol();
        time t0;
        wr_reg(4'h4, 16'h0006);
        wr_reg(4'h0, 16'h0002);
        wr_reg(4'h3, 16'h8009);
        repeat (3) @(posedge so);
        t0 = $time;
        repeat (16) @(posedge so);
        chk(16'(($time - t0) / 40), 16'h0188);
        wr_reg(4'h3, 16'h0009);
        wr_reg(4'h5, 16'h0000);
        wr_reg(4'h4, 16'h0002);
        ticks(4);
        chk({12'h000, wa, wb, wc, wd}, 16'h000F);
        wr_reg(4'h5, 16'h0021);
        wave(8'h18, 8'h13, 8'h0F);
        chk(16'(seen[3]), 16'h000F);
        wr_reg(4'h4, 16'h0006);
    endtask

    task automatic t_inputs();
        logic any;
        any = 1'b0;
        wr_reg(4'h5, 16'h0003);
        ticks(30);
        kick <= 1'b1;
        ticks(1);
        kick <= 1'b0;
        ticks(8);
        rd_reg(4'h7, 16'h000D);
        chk({15'h0000, irq}, 16'h0001);
        wr_reg(4'h5, 16'h0019);
        hold <= 1'b1;
        ticks(5);
        repeat (40)
        begin
            @(posedge clk);
            any = any | wa | wb;
        end
        chk({15'h0000, any}, 16'h0000);
        rd_reg(4'h7, 16'h000F);
        hold <= 1'b0;
        wr_reg(4'h5, 16'h0000);
        ticks(5);
        wr_reg(4'h7, 16'h0007);
        ticks(3);
        rd_reg(4'h7, 16'h0000);
        chk({15'h0000, irq}, 16'h0000);
    endtask

    task automatic t_chain();
        int n;
        n = 0;
        wr_reg(4'h5, 16'h0001);
        @(posedge so);
        // four whole cycles: two adc points per four-ramp cycle
        repeat (96)
        begin
            @(posedge clk);
            n = n + adc;
        end
        chk(16'(n), 16'h0008);
        wr_reg(4'h4, 16'h0046);
        wave(8'h30, 8'h0A, 8'h12);
        wr_reg(4'h4, 16'h0086);
        halt <= 1'b1;
        ticks(6);
        chk({15'h0000, ho}, 16'h0001);
        n = 0;
        // restarts every 10 clocks keep a 24-clock cycle from ever ending
        for (int i = 0; i < 70; i++)
        begin
            syn <= (i % 10 == 0);
            if (i == 5)
                halt <= 1'b0;
            @(posedge clk);
            if (i >= 20)
                n = n + so;
        end
        chk(16'(n), 16'h0000);
        chk({15'h0000, ho}, 16'h0000);
    endtask

    task automatic t_emerg_reset();
        wr_reg(4'h5, 16'h0001);
        fuse <= 1'b1;
        emg <= 1'b1;
        ticks(6);
        chk({15'h0000, oen}, 16'h0001);
        fuse <= 1'b0;
        ticks(6);
        chk({11'h000, oen, wa, wb, wc, wd}, 16'h0000);
        emg <= 1'b0;
        ticks(40);
        rst <= 1'b1;
        ticks(2);
        rst <= 1'b0;
        ticks(1);
        chk({11'h000, ho, wa, wb, wc, wd}, 16'h0010);
        rd_reg(4'h8, 16'h0000);
        rd_reg(4'h4, 16'h0004);
    endtask

    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        ticks(12);
        rst <= 1'b0;
        t_reset_vals();
        t_modes();
        t_hold();
        t_frac_pol();
        t_inputs();
        t_chain();
        t_emerg_reset();
        end_sim();
    end

    // about five times the expected run length
    initial
    begin
        #400000;
        miscompares++;
        end_sim();
    end
endmodule // power_stage_waveform_controller_test
